// ### verilog/cip_top.sv
/*
  Per-core interrupt pending/enable controller with an APB register slave.
  Four cores, 80 sources each: 64 peripheral lines and 16 local sources.
  Assumes peripheral lines, core inputs, halts and mailbox are asynchronous;
  event pulses and burst signals come from logic on pclk.
*/
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps
module cip_top
  import cip_pkg::*;
#(
  parameter int NUM_CORES = cip_pkg::CIP_NUM_CORES
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [cip_pkg::CIP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [cip_pkg::CIP_PER_W-1:0] periph_irq,
  input  wire logic [NUM_CORES-1:0]       core_irq_in,
  input  wire logic                       vector_core0_halt,
  input  wire logic                       vector_core1_halt,
  input  wire logic                       mailbox0_irq,
  input  wire logic                       bus_error_pulse,
  input  wire logic                       burst_access,
  input  wire logic [3:0]                 burst_length_field,
  input  wire logic                       timer_event,
  input  wire logic                       doorbell0_event,
  input  wire logic                       doorbell1_event,
  output logic      [NUM_CORES-1:0]       core_line,
  output logic                            irq
);

  localparam int ASYNC_W = CIP_PER_W + NUM_CORES + 3;

  // classify an address; shared by the read and write paths
  function automatic cip_kind_t reg_kind(input logic [CIP_ADDR_W-1:0] a);
    logic [5:0] sub;
    sub = a[5:0];
    reg_kind = CIP_K_NONE;
    if (a >= CIP_CORE_LO && a <= CIP_CORE_HI && sub[1:0] == 2'b00
        && sub[3:2] <= CIP_WORD_HIGH) begin
      unique case ({sub[5:4], 4'h0})
        CIP_SUB_PEND: reg_kind = CIP_K_PEND;
        CIP_SUB_SET:  reg_kind = CIP_K_SET;
        CIP_SUB_CLR:  reg_kind = CIP_K_CLR;
        default:      reg_kind = CIP_K_NONE;
      endcase
    end else begin
      unique case (a)
        CIP_OFF_SW_SET:    reg_kind = CIP_K_SWSET;
        CIP_OFF_SW_CLR:    reg_kind = CIP_K_SWCLR;
        CIP_OFF_INT_STAT:  reg_kind = CIP_K_STAT;
        CIP_OFF_INT_MASK:  reg_kind = CIP_K_MASK;
        CIP_OFF_CONFIG:    reg_kind = CIP_K_CFG;
        CIP_OFF_BELL0:     reg_kind = CIP_K_BELL0;
        CIP_OFF_BELL1:     reg_kind = CIP_K_BELL1;
        CIP_OFF_TIMER_CTL: reg_kind = CIP_K_TIMER;
        default:           reg_kind = CIP_K_NONE;
      endcase
    end
  endfunction

  logic [ASYNC_W-1:0]     sync1_reg;
  logic [ASYNC_W-1:0]     sync2_reg;
  logic [CIP_PER_W-1:0]   periph_s;
  logic [NUM_CORES-1:0]   core_irq_s;
  logic                   vc0_s;
  logic                   vc1_s;
  logic                   mbox_s;
  logic [CIP_SOFT_W-1:0]  soft_trigger_bits;
  logic                   bus_err_reg;
  logic                   burst_err_reg;
  logic                   doorbell0_flag;
  logic                   doorbell1_flag;
  logic                   timer_flag;
  logic [31:0]            config_reg;
  logic [CIP_INT_W-1:0]   int_stat_reg;
  logic [CIP_INT_W-1:0]   int_mask_reg;
  logic [NUM_CORES-1:0]   line_d_reg;
  logic [CIP_LOCAL_W-1:0] local_src;
  logic [CIP_SRC_W-1:0]   all_src;
  logic [CIP_SRC_W-1:0]   enable_reg [NUM_CORES];
  logic [CIP_SRC_W-1:0]   pending    [NUM_CORES];
  logic [31:0]            high_word  [NUM_CORES];
  logic [31:0]            prdata_reg;
  logic                   slverr_reg;
  logic [31:0]            read_next;
  cip_kind_t              kind;
  logic [1:0]             core_sel;
  logic [1:0]             word_sel;
  logic                   setup_ph;
  logic                   wr_fire;
  logic                   rd_fire;

  // two-flop synchroniser for every asynchronous input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {periph_irq, core_irq_in, vector_core0_halt, vector_core1_halt,
                    mailbox0_irq};
      sync2_reg <= sync1_reg;
    end
  end

  assign periph_s   = sync2_reg[ASYNC_W-1 -: CIP_PER_W];
  assign core_irq_s = sync2_reg[NUM_CORES+2:3];
  assign vc0_s      = sync2_reg[2];
  assign vc1_s      = sync2_reg[1];
  assign mbox_s     = sync2_reg[0];

  // bus decode
  assign kind     = reg_kind(paddr);
  assign core_sel = paddr[7:6];
  assign word_sel = paddr[3:2];
  assign setup_ph = psel && !penable;
  assign wr_fire  = psel && penable && pwrite;
  assign rd_fire  = psel && penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_trigger_bits <= '0;
    end else if (wr_fire && kind == CIP_K_SWSET) begin
      soft_trigger_bits <= soft_trigger_bits | pwdata[CIP_SOFT_W-1:0];
    end else if (wr_fire && kind == CIP_K_SWCLR) begin
      soft_trigger_bits <= soft_trigger_bits & ~pwdata[CIP_SOFT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_err_reg   <= 1'b0;
      burst_err_reg <= 1'b0;
    end else begin
      if (bus_error_pulse) begin
        bus_err_reg <= 1'b1;
      end
      if (burst_access && burst_length_field != 4'h0) begin
        burst_err_reg <= 1'b1;
      end
    end
  end

  // doorbell and timer flags, an event wins over its clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      doorbell0_flag <= 1'b0;
      doorbell1_flag <= 1'b0;
      timer_flag     <= 1'b0;
    end else begin
      doorbell0_flag <= doorbell0_event ||
                        (doorbell0_flag && !(rd_fire && kind == CIP_K_BELL0));
      doorbell1_flag <= doorbell1_event ||
                        (doorbell1_flag && !(rd_fire && kind == CIP_K_BELL1));
      timer_flag     <= timer_event ||
                        (timer_flag && !(wr_fire && kind == CIP_K_TIMER));
    end
  end

  // configuration and interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg   <= CIP_RST_WORD;
      int_mask_reg <= '0;
    end else if (wr_fire && kind == CIP_K_CFG) begin
      config_reg <= pwdata;
    end else if (wr_fire && kind == CIP_K_MASK) begin
      int_mask_reg <= pwdata[CIP_INT_W-1:0];
    end
  end

  // sticky status: core line rise and bus error; write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
      line_d_reg   <= '0;
    end else begin
      line_d_reg   <= core_line;
      int_stat_reg <= {bus_error_pulse, core_line & ~line_d_reg} |
                      (int_stat_reg & ~((wr_fire && kind == CIP_K_STAT) ?
                                        pwdata[CIP_INT_W-1:0] : '0));
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);

  // halt merge; local group of the high word
  assign local_src = {soft_trigger_bits, bus_err_reg, burst_err_reg, vc1_s,
                      vc0_s | (config_reg[CIP_CFG_MERGE] & vc1_s),
                      doorbell1_flag, doorbell0_flag, mbox_s, timer_flag};
  assign all_src = {local_src, periph_s};

  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    cip_core_slice #(
      .SRC_W (CIP_SRC_W)
    ) u_slice (
      .pclk       (pclk),
      .presetn    (presetn),
      .set_we     (wr_fire && kind == CIP_K_SET && core_sel == 2'(c)),
      .clr_we     (wr_fire && kind == CIP_K_CLR && core_sel == 2'(c)),
      .word_sel   (word_sel),
      .wdata      (pwdata),
      .src_level  (all_src),
      .enable_reg (enable_reg[c]),
      .pending    (pending[c]),
      .core_line  (core_line[c])
    );
    assign high_word[c] = {core_irq_s[c], 5'h00, |pending[c][63:32],
                           |pending[c][31:0], 8'h00, pending[c][79:64]};
  end

  // read multiplexer
  always_comb begin
    read_next = CIP_RST_WORD;
    unique case (kind)
      CIP_K_PEND: begin
        unique case (word_sel)
          2'h0:    read_next = pending[core_sel][31:0];
          2'h1:    read_next = pending[core_sel][63:32];
          default: read_next = high_word[core_sel];
        endcase
      end
      CIP_K_SET, CIP_K_CLR: begin
        unique case (word_sel)
          2'h0:    read_next = enable_reg[core_sel][31:0];
          2'h1:    read_next = enable_reg[core_sel][63:32];
          default: read_next = {16'h0000, enable_reg[core_sel][79:64]};
        endcase
      end
      CIP_K_SWSET, CIP_K_SWCLR: read_next = {24'h000000, soft_trigger_bits};
      CIP_K_STAT:  read_next = {27'h0, int_stat_reg};
      CIP_K_MASK:  read_next = {27'h0, int_mask_reg};
      CIP_K_CFG:   read_next = config_reg;
      CIP_K_BELL0: read_next = {31'h0, doorbell0_flag};
      CIP_K_BELL1: read_next = {31'h0, doorbell1_flag};
      CIP_K_TIMER: read_next = {31'h0, timer_flag};
      default:     read_next = CIP_RST_WORD;
    endcase
  end

  // capture read data and error in the setup cycle; no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= CIP_RST_WORD;
      slverr_reg <= 1'b0;
    end else if (setup_ph) begin
      prdata_reg <= pwrite ? CIP_RST_WORD : read_next;
      slverr_reg <= (kind == CIP_K_NONE);
    end
  end

  assign prdata  = prdata_reg;
  assign pslverr = slverr_reg;
  assign pready  = 1'b1;

  a_soft_set_ones: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && kind == CIP_K_SWSET) |=>
      ((soft_trigger_bits & $past(pwdata[7:0])) == $past(pwdata[7:0])))
    else $error("soft trigger not set by write of ones");
  a_soft_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_fire && kind == CIP_K_SWCLR) |=>
      ((soft_trigger_bits & $past(soft_trigger_bits)) == $past(soft_trigger_bits)))
    else $error("soft trigger dropped without a clear write");
  a_bus_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    bus_error_pulse |=> bus_err_reg [*8])
    else $error("bus error flag not held");
  a_burst_detect: assert property (@(posedge pclk) disable iff (!presetn)
    (burst_access && burst_length_field == 4'h0 && !burst_err_reg) |=> !burst_err_reg)
    else $error("burst flag set by a single-beat access");
  a_burst_set: assert property (@(posedge pclk) disable iff (!presetn)
    (burst_access && burst_length_field != 4'h0) |=> burst_err_reg)
    else $error("burst flag not set by a burst access");
  a_halt_merge: assert property (@(posedge pclk) disable iff (!presetn)
    (!config_reg[CIP_CFG_MERGE] && !vc0_s) |-> !local_src[CIP_L_VC01])
    else $error("merged halt bit set while merge disabled");
  a_bell_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_fire && kind == CIP_K_BELL0 && !doorbell0_event) |=> !doorbell0_flag)
    else $error("doorbell 0 flag not cleared by read");
  a_timer_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && kind == CIP_K_TIMER && !timer_event) |=> !timer_flag)
    else $error("timer flag not cleared by control write");
  a_high_word_read: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ph && !pwrite && kind == CIP_K_PEND && word_sel == CIP_WORD_HIGH) |=>
      (prdata[30:26] == 5'h00 && prdata[23:16] == 8'h00 &&
       prdata[31] == $past(core_irq_s[core_sel])))
    else $error("high pending word reserved or level bit wrong");

  c_soft_irq: cover property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && kind == CIP_K_SWSET) ##[1:20] core_line[1]);
  c_enable_then_line: cover property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && kind == CIP_K_SET) ##[1:40] irq);
  c_bell_read: cover property (@(posedge pclk) disable iff (!presetn)
    doorbell0_flag ##[1:20] (rd_fire && kind == CIP_K_BELL0));
  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
    rd_fire && pslverr);

endmodule

// ### verilog/cip_pkg.sv
/*
  Constants and types shared by the per-core interrupt pending/enable block:
  register offsets, field positions, reset values and the register kind enum.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
package cip_pkg;

  // sizes
  localparam int CIP_NUM_CORES = 4;
  localparam int CIP_SRC_W     = 80;
  localparam int CIP_PER_W     = 64;
  localparam int CIP_LOCAL_W   = 16;
  localparam int CIP_ADDR_W    = 12;
  localparam int CIP_SOFT_W    = 8;
  localparam int CIP_INT_W     = 5;

  // per-core window: core index in addr[7:6], sub offset in addr[5:0]
  localparam logic [11:0] CIP_CORE_LO  = 12'h200;
  localparam logic [11:0] CIP_CORE_HI  = 12'h2FF;
  localparam logic [5:0]  CIP_SUB_PEND = 6'h00;
  localparam logic [5:0]  CIP_SUB_SET  = 6'h10;
  localparam logic [5:0]  CIP_SUB_CLR  = 6'h20;
  localparam logic [1:0]  CIP_WORD_HIGH = 2'h2;

  // global registers
  localparam logic [11:0] CIP_OFF_SW_SET    = 12'h3F0;
  localparam logic [11:0] CIP_OFF_SW_CLR    = 12'h3F4;
  localparam logic [11:0] CIP_OFF_INT_STAT  = 12'h100;
  localparam logic [11:0] CIP_OFF_INT_MASK  = 12'h104;
  localparam logic [11:0] CIP_OFF_CONFIG    = 12'h108;
  localparam logic [11:0] CIP_OFF_BELL0     = 12'h110;
  localparam logic [11:0] CIP_OFF_BELL1     = 12'h114;
  localparam logic [11:0] CIP_OFF_TIMER_CTL = 12'h118;

  // high pending word fields and the config merge bit
  localparam int CIP_HI_IRQ_BIT  = 31;
  localparam int CIP_HI_MID_ANY  = 25;
  localparam int CIP_HI_LOW_ANY  = 24;
  localparam int CIP_CFG_MERGE   = 10;

  // local source positions within the 16-bit high group
  localparam int CIP_L_SOFT_LSB = 8;
  localparam int CIP_L_BUS_ERR  = 7;
  localparam int CIP_L_BURST    = 6;
  localparam int CIP_L_VC1      = 5;
  localparam int CIP_L_VC01     = 4;
  localparam int CIP_L_BELL1    = 3;
  localparam int CIP_L_BELL0    = 2;
  localparam int CIP_L_MBOX     = 1;
  localparam int CIP_L_TIMER    = 0;

  // interrupt status: bits 3:0 core line rise, bit 4 bus error
  localparam int CIP_INT_BUS_ERR = 4;

  // reset values
  localparam logic [31:0] CIP_RST_WORD = 32'h0000_0000;

  typedef enum logic [3:0] {
    CIP_K_NONE  = 4'b0000,
    CIP_K_PEND  = 4'b0001,
    CIP_K_SET   = 4'b0010,
    CIP_K_CLR   = 4'b0011,
    CIP_K_SWSET = 4'b0100,
    CIP_K_SWCLR = 4'b0101,
    CIP_K_STAT  = 4'b0110,
    CIP_K_MASK  = 4'b0111,
    CIP_K_CFG   = 4'b1000,
    CIP_K_BELL0 = 4'b1001,
    CIP_K_BELL1 = 4'b1010,
    CIP_K_TIMER = 4'b1011
  } cip_kind_t;

endpackage

// ### verilog/cip_core_slice.sv
/*
  One core's enable state and masked pending vector.
  Assumes set/clear strobes are one-cycle pulses from the bus slave, never both
  at once, and that sources are already synchronous to pclk.
*/
`timescale 1ns/1ps
module cip_core_slice
  import cip_pkg::*;
#(
  parameter int SRC_W = cip_pkg::CIP_SRC_W
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             set_we,
  input  wire logic             clr_we,
  input  wire logic [1:0]       word_sel,
  input  wire logic [31:0]      wdata,
  input  wire logic [SRC_W-1:0] src_level,
  output logic      [SRC_W-1:0] enable_reg,
  output logic      [SRC_W-1:0] pending,
  output logic                  core_line
);

  logic [95:0]      wide_mask;
  logic [SRC_W-1:0] word_mask;

  // place the written word over its 32-bit lane
  assign wide_mask = {64'h0, wdata} << {word_sel, 5'b00000};
  assign word_mask = wide_mask[SRC_W-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= '0;
    end else if (set_we) begin
      enable_reg <= enable_reg | word_mask;
    end else if (clr_we) begin
      enable_reg <= enable_reg & ~word_mask;
    end
  end

  assign pending = src_level & enable_reg;
  assign core_line = |pending;

  a_disabled_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pending & ~enable_reg) == '0)
    else $error("pending bit shown for a disabled source");
  a_set_only_adds: assert property (@(posedge pclk) disable iff (!presetn)
    set_we |=> (enable_reg == ($past(enable_reg) | $past(word_mask))))
    else $error("set write did not add exactly the written ones");
  a_clr_only_removes: assert property (@(posedge pclk) disable iff (!presetn)
    clr_we |=> (enable_reg == ($past(enable_reg) & ~$past(word_mask))))
    else $error("clear write did not remove exactly the written ones");
  a_enable_no_overwrite: assert property (@(posedge pclk) disable iff (!presetn)
    (!set_we && !clr_we) |=> $stable(enable_reg))
    else $error("enable state changed without a set or clear write");
  a_line_follows: assert property (@(posedge pclk) disable iff (!presetn)
    core_line == (pending != '0))
    else $error("core line does not match pending bits");

endmodule

// ### bench/cip_src_model.sv
/*
  Source-side model: peripheral levels, core inputs, halts, mailbox and pulses.
  Assumes the bench calls its tasks; outputs move just after pclk rises.
*/
`timescale 1ns/1ps
module cip_src_model (
  input  wire logic        pclk,
  output logic      [63:0] periph_irq,
  output logic      [3:0]  core_irq_in,
  output logic      [1:0]  halt,
  output logic             mbox,
  output logic      [3:0]  ev,
  output logic             burst,
  output logic      [3:0]  blen
);
  // everything quiet at time zero
  initial begin
    {periph_irq, core_irq_in, halt, mbox, ev, burst, blen} = '0;
  end
  // held levels; hm is {vc1 halt, vc0 halt, mailbox}
  task automatic lv(input logic [63:0] p, input logic [3:0] c, input logic [2:0] hm);
    @(posedge pclk);
    periph_irq <= p;
    core_irq_in <= c;
    {halt, mbox} <= hm;
  endtask
  // one-cycle pulse; e is {bell1, bell0, timer, bus error}
  task automatic pl(input logic [3:0] e, input logic b, input logic [3:0] l);
    @(posedge pclk);
    ev <= e;
    burst <= b;
    blen <= l;
    @(posedge pclk);
    ev <= '0;
    burst <= 1'b0;
    blen <= ~l;  // length no longer qualified
  endtask
endmodule

// ### bench/test_core_irq_pending_enable.sv
/*
  Self-checking bench for cip_top: APB tasks note expected reads in a queue
  and a monitor compares them as reads complete. Assumes cip_pkg and the model.
*/
`timescale 1ns/1ps
module test_core_irq_pending_enable;
  import cip_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, hb, r;
  logic [63:0] per, pv, p;
  logic [63:0] en[4];
  logic [3:0]  cin, cl, blen, ev;
  logic [1:0]  halt;
  logic        mbox, burst;
  logic [64:0] e;
  logic [64:0] q[$];
  int          n_mismatch, comparisons, seed;

  cip_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .periph_irq(per), .core_irq_in(cin), .vector_core0_halt(halt[0]),
    .vector_core1_halt(halt[1]), .mailbox0_irq(mbox), .bus_error_pulse(ev[0]),
    .burst_access(burst), .burst_length_field(blen), .timer_event(ev[1]),
    .doorbell0_event(ev[2]), .doorbell1_event(ev[3]), .core_line(cl), .irq(irq));
  cip_src_model src (.pclk(pclk), .periph_irq(per), .core_irq_in(cin), .halt(halt),
    .mbox(mbox), .ev(ev), .burst(burst), .blen(blen));

  // 20 MHz clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] m);
    comparisons++;
    if ((seen & m) !== (exp & m)) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // oldest note against each completed read: {err, mask, data}
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      e = q.pop_front();
      chk(prdata, e[31:0], e[63:32]);
      chk({31'h0, pslverr}, {31'h0, e[64]}, 32'h1);
    end
  end

  // setup, then access held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready seen high ends this wait; the watchdog covers a stuck slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m = '1,
                    input logic er = 1'b0);
    q.push_back({er, m, d});
    xfer(1'b0, a, 32'h0);
  endtask
  function automatic logic [11:0] ca(input logic [1:0] c, input logic [5:0] s);
    return CIP_CORE_LO + {4'h0, c, s};
  endfunction
  task automatic tend(input string s);
    $display("test %s finished", s);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    seed = 32'hB2A3;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      rd(ca(2'(c), CIP_SUB_PEND), 32'h0);
      rd(ca(2'(c), CIP_SUB_PEND + 6'h04), 32'h0);
      rd(ca(2'(c), CIP_SUB_SET), 32'h0);
    end
    rd(12'h0FC, 32'h0, 32'hFFFF_FFFF, 1'b1);
    tend("reset");
    // random sources, separate enables per core
    pv = {$random(seed), $random(seed)};
    src.lv(pv, 4'h0, 3'h0);
    for (int c = 0; c < 4; c++) begin
      en[c] = {$random(seed), $random(seed)};
      wr(ca(2'(c), CIP_SUB_SET), en[c][31:0]);
      wr(ca(2'(c), CIP_SUB_SET + 6'h04), en[c][63:32]);
    end
    for (int c = 0; c < 4; c++) begin
      p = pv & en[c];
      rd(ca(2'(c), CIP_SUB_PEND), p[31:0]);
      rd(ca(2'(c), CIP_SUB_PEND + 6'h04), p[63:32]);
      rd(ca(2'(c), CIP_SUB_CLR + 6'h04), en[c][63:32]);
      rd(ca(2'(c), CIP_SUB_PEND + 6'h08), {6'h0, |p[63:32], |p[31:0], 24'h0});
      chk({31'h0, cl[c]}, {31'h0, |p}, 32'h1);
    end
    r = $random(seed);
    wr(ca(2'd0, CIP_SUB_SET), r);
    en[0][31:0] = en[0][31:0] | r;
    rd(ca(2'd0, CIP_SUB_SET), en[0][31:0]);
    r = $random(seed);
    wr(ca(2'd0, CIP_SUB_CLR), r);
    en[0][31:0] = en[0][31:0] & ~r;
    rd(ca(2'd0, CIP_SUB_CLR), en[0][31:0]);
    wr(ca(2'd0, CIP_SUB_PEND), 32'hFFFF_FFFF);
    rd(ca(2'd0, CIP_SUB_PEND), pv[31:0] & en[0][31:0]);
    tend("enables");
    // local sources seen through core 1
    p = pv & en[1];
    hb = {6'h0, |p[63:32], |p[31:0], 24'h0};
    wr(ca(2'd1, CIP_SUB_SET + 6'h08), 32'hFFFF_FFFF);
    rd(ca(2'd1, CIP_SUB_SET + 6'h08), 32'h0000_FFFF);
    wr(CIP_OFF_SW_SET, 32'hA5);
    rd(CIP_OFF_SW_SET, 32'h0000_00A5);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hA500);
    wr(ca(2'd1, CIP_SUB_PEND + 6'h08), 32'h0);
    wr(CIP_OFF_SW_CLR, 32'h05);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hA000);
    wr(CIP_OFF_SW_CLR, 32'hFF);
    src.pl(4'b0001, 1'b0, 4'h0);
    src.pl(4'b0000, 1'b1, 4'h0);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'h80);
    src.pl(4'b0000, 1'b1, 4'h3);
    src.pl(4'b0010, 1'b0, 4'h0);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hC1);
    rd(CIP_OFF_TIMER_CTL, 32'h0000_0001);
    wr(CIP_OFF_TIMER_CTL, 32'h0);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hC0);
    src.pl(4'b1100, 1'b0, 4'h0);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hCC);
    rd(CIP_OFF_BELL0, 32'h0000_0001);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hC8);
    rd(CIP_OFF_BELL1, 32'h0000_0001);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hC0);
    src.lv(pv, 4'h2, 3'b010);
    repeat (3) @(posedge pclk);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'h8000_00D0);
    src.lv(pv, 4'h0, 3'b101);
    repeat (3) @(posedge pclk);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hE2);
    wr(CIP_OFF_CONFIG, 32'h400);
    rd(CIP_OFF_CONFIG, 32'h0000_0400);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hF2);
    chk({31'h0, cl[1]}, 32'h1, 32'h1);
    tend("local");
    // interrupt: bus error status raised, masked, cleared
    wr(CIP_OFF_INT_MASK, 32'h10);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1, 32'h1);
    rd(CIP_OFF_INT_MASK, 32'h0000_0010);
    wr(CIP_OFF_INT_MASK, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0, 32'h1);
    wr(CIP_OFF_INT_MASK, 32'h10);
    wr(CIP_OFF_INT_STAT, 32'h10);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0, 32'h1);
    rd(CIP_OFF_INT_STAT, 32'h0, 32'h10);
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), hb | 32'hF2);
    tend("interrupt");
    // second reset clears core 1's high pending and enable words
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ca(2'd1, CIP_SUB_PEND + 6'h08), 32'h0);
    rd(ca(2'd1, CIP_SUB_SET + 6'h08), 32'h0);
    tend("rereset");
    report_and_stop();
  end
endmodule
